// ===== hw/dic_top.sv
/*
 * Digital input conditioning: sampling, inversion, forcing,
 * special-function gating and optional source routing.
 * Assumes inputs synchronous to i_clk and a bus master that never
 * issues read and write strobes together.
 */
`timescale 1ns/10ps
module dic_top #(
    parameter int SAMPLE_CYCLES = dic_pkg::SAMPLE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [dic_pkg::N_IN-1:0] i_din,
    input wire dic_pkg::dic_sens_s i_sens,
    input wire dic_pkg::dic_bus_s i_bus,
    output logic [dic_pkg::WORD_W-1:0] o_rdata,
    output logic [dic_pkg::WORD_W-1:0] o_digital_inputs,
    output logic [dic_pkg::N_THR-1:0] o_range_sel,
    output logic o_interlock_trip
);
    import dic_pkg::*;

    localparam int CNT_W = $clog2(SAMPLE_CYCLES);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_CYCLES - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] div;
        logic [N_IN-1:0] raw;
        dic_sens_s sens;
        logic [N_SPECIAL-1:0] special_en;
        logic [N_IN-1:0] invert;
        logic [N_IN-1:0] force_en;
        logic [N_IN-1:0] force_val;
        logic [N_THR-1:0] threshold;
        logic route_en;
        logic [WORD_W-1:0][CODE_W-1:0] table_code;
        logic [WORD_W-1:0] digital_in;
        logic [WORD_W-1:0] rdata;
        logic trip;
    } dic_state_s;

    dic_state_s st;
    dic_state_s next_st;

    logic [N_IN-1:0] level;
    logic [WORD_W-1:0] fixed_word;
    logic [WORD_W-1:0] routed_word;
    logic [WORD_W-1:0][CODE_W-1:0] preload;

    // ------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------
    function automatic logic src_bit(
        input logic [CODE_W-1:0] code,
        input logic [N_IN-1:0] lvl,
        input dic_sens_s sens
    );
        logic [6:0] base;
        logic val;
        base = code[6:0];
        val = 1'b0;
        if (base != SRC_ZERO && base <= SRC_IN_LAST) begin
            // Inputs beyond those fitted read as zero
            if (int'(base) <= N_IN) begin
                val = lvl[int'(base) - 1];
            end
        end else begin
            case (base)
                SRC_HALL_U: val = sens.hall[0];
                SRC_HALL_V: val = sens.hall[1];
                SRC_HALL_W: val = sens.hall[2];
                SRC_ENC_A: val = sens.enc[0];
                SRC_ENC_B: val = sens.enc[1];
                SRC_ENC_IDX: val = sens.enc[2];
                SRC_NET: val = sens.net;
                default: val = 1'b0;
            endcase
        end
        return val ^ code[SRC_INV_BIT];
    endfunction : src_bit

    // ------------------------------------------------------------
    // Per-input levels
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_in
            // One continuous driver per bit keeps each bit single-sourced
            assign level[gi] = st.force_en[gi] ?
                st.force_val[gi] :
                (st.raw[gi] ^ st.invert[gi]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Per-bit word build
    // ------------------------------------------------------------
    genvar gb;
    generate
        for (gb = 0; gb < WORD_W; gb++) begin : g_bit
            // Entry gb decides word bit gb
            assign routed_word[gb] = src_bit(st.table_code[gb], level, st.sens);

            if (gb < N_SPECIAL && gb < N_IN) begin : g_sf
                assign fixed_word[gb] = level[gb];
                assign preload[gb] = CODE_W'(gb + 1);
            end else if (gb >= LVL_BASE && gb - LVL_BASE < N_IN) begin : g_lvl
                assign fixed_word[gb] = level[gb - LVL_BASE];
                assign preload[gb] = CODE_W'(gb - LVL_BASE + 1);
            end else begin : g_none
                assign fixed_word[gb] = 1'b0;
                assign preload[gb] = RST_CODE;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic tick;
        logic [WORD_W-1:0] word;
        logic [TBL_IDX_W-1:0] idx;
        tick = 1'b0;
        word = '0;
        idx = '0;
        next_st = st;

        // Millisecond sample tick
        tick = (st.div == CNT_LAST);
        next_st.div = tick ? '0 : st.div + 1'b1;
        if (tick) begin
            next_st.raw = i_din;
            next_st.sens = i_sens;
        end

        // Fixed map unless routing active
        word = st.route_en ? routed_word : fixed_word;
        // Gate only the special bits; levels above stay untouched
        word[N_SPECIAL-1:0] = word[N_SPECIAL-1:0] & st.special_en;
        next_st.digital_in = word;
        next_st.trip = st.special_en[SF_INTERLOCK] & ~word[SF_INTERLOCK];

        idx = i_bus.addr[TBL_IDX_LSB +: TBL_IDX_W];

        // Register writes
        if (i_bus.wr) begin
            if (i_bus.addr[TBL_SEL_BIT]) begin
                next_st.table_code[idx] = i_bus.wdata[CODE_W-1:0];
            end else begin
                case (i_bus.addr)
                    OFS_SPECIAL_EN: next_st.special_en = i_bus.wdata[N_SPECIAL-1:0];
                    OFS_INVERT: next_st.invert = i_bus.wdata[N_IN-1:0];
                    OFS_FORCE_EN: next_st.force_en = i_bus.wdata[N_IN-1:0];
                    OFS_FORCE_VAL: next_st.force_val = i_bus.wdata[N_IN-1:0];
                    OFS_THRESHOLD: next_st.threshold = i_bus.wdata[N_THR-1:0];
                    OFS_ROUTE_EN: begin
                        next_st.route_en = i_bus.wdata[0];
                        // Preload only on entry, so a table set up earlier is
                        // lost each time routing is switched off and on again
                        if (i_bus.wdata[0] && !st.route_en) begin
                            next_st.table_code = preload;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // Register reads, data one cycle later
        next_st.rdata = RST_WORD;
        if (i_bus.rd) begin
            if (i_bus.addr[TBL_SEL_BIT]) begin
                next_st.rdata = WORD_W'(st.table_code[idx]);
            end else begin
                case (i_bus.addr)
                    OFS_SPECIAL_EN: next_st.rdata = WORD_W'(st.special_en);
                    OFS_INVERT: next_st.rdata = WORD_W'(st.invert);
                    OFS_FORCE_EN: next_st.rdata = WORD_W'(st.force_en);
                    OFS_FORCE_VAL: next_st.rdata = WORD_W'(st.force_val);
                    OFS_RAW: next_st.rdata = WORD_W'(st.raw);
                    OFS_THRESHOLD: next_st.rdata = WORD_W'(st.threshold);
                    OFS_ROUTE_EN: next_st.rdata = WORD_W'(st.route_en);
                    OFS_DIGITAL_IN: next_st.rdata = st.digital_in;
                    default: next_st.rdata = RST_WORD;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata = st.rdata;
    assign o_digital_inputs = st.digital_in;
    // Drives the analog comparator reference select
    assign o_range_sel = st.threshold;
    assign o_interlock_trip = st.trip;

endmodule : dic_top

// ===== hw/dic_pkg.sv
/*
 * Constants and carrier types for the digital input conditioning block.
 * Assumes a single 50 MHz clock and a plain address/strobe register port.
 */
// What this block does
// - Sample every digital input once per millisecond; shorter pulses may vanish.
// - Enable bits 0..3 gate negative limit, positive limit, home, interlock.
// - Special-function enables touch only bits 0..15; level bits always produced.
// - Inversion bit n-1: 0 normally open, 1 normally closed for input n.
// - Force-enable bit n-1 replaces input n's sampled level by software value.
// - Force-value bit is the level used while its force-enable bit is set.
// - Raw-value register shows sampled levels before inversion, forcing, routing.
// - Threshold bit n-1 for inputs 1..4: 0 picks 5 V, 1 picks 24 V.
// - Bit 0 is negative limit; input 1 level in bit 16, upward.
// - Routing mode only when routing enable written 1; else fixed mapping.
// - Routing entry k drives word bit k; entry for bit 16 is at offset 0xC0.
// - Codes: 0 zero, 1..16 inputs, 41..43 Hall, 44..46 encoder, 48 network.
// - Adding 0x80 inverts the source; 0x80 is constant one.
// - Enabling routing preloads the table so inputs behave as before.
// - Interlock enabled: word bit 3 low trips the fault reaction.
// - Bits 0..15 carry special results, bits 16..31 plain levels.
package dic_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int SAMPLE_PERIOD_US = 1000;
    localparam int SAMPLE_CYCLES = (CLK_HZ / 1_000_000) * SAMPLE_PERIOD_US;

    // ------------------------------------------------------------
    // Sizes and word layout
    // ------------------------------------------------------------
    localparam int N_IN = 6;
    localparam int N_THR = 4;
    localparam int N_SPECIAL = 4;
    localparam int WORD_W = 32;
    localparam int LVL_BASE = 16;
    localparam int ADDR_W = 8;
    localparam int CODE_W = 8;
    localparam int SF_INTERLOCK = 3;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_SPECIAL_EN = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_INVERT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FORCE_EN = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_FORCE_VAL = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_RAW = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_THRESHOLD = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_ROUTE_EN = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_DIGITAL_IN = 8'h24;
    localparam int TBL_SEL_BIT = 7;
    localparam int TBL_IDX_LSB = 2;
    localparam int TBL_IDX_W = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [WORD_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [CODE_W-1:0] RST_CODE = 8'h00;

    // ------------------------------------------------------------
    // Routing source codes
    // ------------------------------------------------------------
    localparam int SRC_INV_BIT = 7;
    localparam logic [6:0] SRC_ZERO = 7'h00;
    localparam logic [6:0] SRC_IN_LAST = 7'h10;
    localparam logic [6:0] SRC_HALL_U = 7'h41;
    localparam logic [6:0] SRC_HALL_V = 7'h42;
    localparam logic [6:0] SRC_HALL_W = 7'h43;
    localparam logic [6:0] SRC_ENC_A = 7'h44;
    localparam logic [6:0] SRC_ENC_B = 7'h45;
    localparam logic [6:0] SRC_ENC_IDX = 7'h46;
    localparam logic [6:0] SRC_NET = 7'h48;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
        logic wr;
        logic rd;
    } dic_bus_s;

    typedef struct packed {
        logic [2:0] hall;
        logic [2:0] enc;
        logic net;
    } dic_sens_s;

endpackage : dic_pkg

// ===== tb/dic_sva.sv
/* Port checker for dic_top.
   Assumes one clock domain and a bind onto every dic_top instance. */
`timescale 1ns/10ps
module dic_sva #(
    parameter int SAMPLE_CYCLES = dic_pkg::SAMPLE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [dic_pkg::N_IN-1:0] i_din,
    input wire dic_pkg::dic_sens_s i_sens,
    input wire dic_pkg::dic_bus_s i_bus,
    input wire logic [dic_pkg::WORD_W-1:0] o_rdata,
    input wire logic [dic_pkg::WORD_W-1:0] o_digital_inputs,
    input wire logic [dic_pkg::N_THR-1:0] o_range_sel,
    input wire logic o_interlock_trip
);
    import dic_pkg::*;
    // ------------------------------------------------------------
    // Shadow of the special-enable, threshold and routing-enable settings
    // ------------------------------------------------------------
    logic [31:0] cnt;
    logic [31:0] w;
    logic [2:0] act;
    logic [2:0] wrs;
    logic [3:0] sf;
    logic [3:0] thr;
    logic rte;
    logic tk;
    logic quiet;
    assign w = o_digital_inputs;
    assign tk = cnt == 32'(SAMPLE_CYCLES - 1);
    // Three quiet cycles let any write reach the word first
    assign quiet = wrs == 3'h0;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt <= 32'h0;
            act <= 3'h0;
            wrs <= 3'h0;
            sf <= 4'h0;
            thr <= 4'h0;
            rte <= 1'b0;
        end else begin
            cnt <= tk ? 32'h0 : cnt + 32'h1;
            act <= {act[1:0], tk | i_bus.wr};
            wrs <= {wrs[1:0], i_bus.wr};
            if (i_bus.wr && i_bus.addr == OFS_SPECIAL_EN) sf <= i_bus.wdata[3:0];
            if (i_bus.wr && i_bus.addr == OFS_THRESHOLD) thr <= i_bus.wdata[3:0];
            if (i_bus.wr && i_bus.addr == OFS_ROUTE_EN) rte <= i_bus.wdata[0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_rdata_idle: assert property (
        !i_bus.rd |=> o_rdata == 32'h0) else $error("read data outside read slot");
    a_unmapped_rd: assert property (
        i_bus.rd && i_bus.addr == 8'h18 |=> o_rdata == 32'h0) else $error("unmapped read");
    a_range_follow: assert property (
        !(i_bus.wr && i_bus.addr == OFS_THRESHOLD) [*3] |-> o_range_sel == thr)
        else $error("threshold select wrong");
    a_sample_hold: assert property (
        $changed(w) |-> act != 3'h0) else $error("word moved between samples");
    a_trip_link: assert property (
        quiet |-> o_interlock_trip == (sf[3] && !w[3])) else $error("trip wrong");
    a_fixed_gate: assert property (
        quiet && !rte |-> w[3:0] == (w[19:16] & sf)) else $error("fixed special bits wrong");
    a_sf_gate: assert property (
        quiet |-> (w[3:0] & ~sf) == 4'h0) else $error("disabled special bit set");
    a_upper_zero: assert property (
        quiet && !rte |-> w[31:22] == 10'h0 && w[15:4] == 12'h0) else $error("stray bits");
    c_routing: cover property (rte && quiet);
    c_trip: cover property (o_interlock_trip);
    c_raw_rd: cover property (i_bus.rd && i_bus.addr == OFS_RAW);
endmodule : dic_sva
bind dic_top dic_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_sva (.i_clk(i_clk), .i_srst(i_srst),
    .i_din(i_din), .i_sens(i_sens), .i_bus(i_bus), .o_rdata(o_rdata),
    .o_digital_inputs(o_digital_inputs), .o_range_sel(o_range_sel),
    .o_interlock_trip(o_interlock_trip));

// ===== tb/dic_sw_model.sv
/* Switch and sensor bank in front of the inputs.
   Assumes the bench sets levels; they move only on rising edges. */
`timescale 1ns/10ps
module dic_sw_model (
    input wire logic i_clk,
    input wire logic [5:0] i_lvl,
    input wire logic [6:0] i_sl,
    output logic [dic_pkg::N_IN-1:0] o_din,
    output dic_pkg::dic_sens_s o_sens
);
    import dic_pkg::*;
    always_ff @(posedge i_clk) begin
        o_din <= i_lvl;
        o_sens <= dic_sens_s'(i_sl);
    end
endmodule : dic_sw_model

// ===== tb/tb_top.sv
/* Self-checking bench for dic_top.
   Assumes dic_sw_model and the bound checker are compiled before it. */
`timescale 1ns/10ps
module tb_top;
    import dic_pkg::*;
    localparam int SC = 8;
    localparam logic [7:0] RA [9] = '{8'h10, 8'h24, 8'h00, 8'h04, 8'h08, 8'h0c, 8'h14,
        8'h20, 8'h80};
    localparam logic [7:0] CD [19] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07,
        8'h10, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h48, 8'h80, 8'h82, 8'hc2, 8'hc8};
    localparam logic [18:0] EX = 19'h3d52a;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] lvl = 6'h2d;
    dic_bus_s bus = 42'h0;
    logic [5:0] din;
    dic_sens_s sens;
    logic [31:0] rdata;
    logic [31:0] word;
    logic [3:0] rsel;
    logic trip;
    int bad_count = 0;
    int checks_done = 0;
    always #10 clk = ~clk;
    dic_sw_model part (.i_clk(clk), .i_lvl(lvl), .i_sl(7'h55), .o_din(din), .o_sens(sens));
    dic_top #(.SAMPLE_CYCLES(SC)) uut (.i_clk(clk), .i_srst(srst), .i_din(din),
        .i_sens(sens), .i_bus(bus), .o_rdata(rdata), .o_digital_inputs(word),
        .o_range_sel(rsel), .o_interlock_trip(trip));
    // ------------------------------------------------------------
    // Bus access and checking
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd
    // Two whole sample periods cover any tick phase
    task automatic settle;
        repeat (2 * SC + 4) @(posedge clk);
        #1;
    endtask : settle
    function automatic logic [31:0] fx(input logic [5:0] l, input logic [3:0] sf);
        return {10'h0, l, 12'h0, l[3:0] & sf};
    endfunction : fx
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        foreach (RA[i]) rd(RA[i], 32'h0);
        settle();
        rd(OFS_RAW, 32'h2d);
        chk(word, fx(6'h2d, 4'h0));
        wr(OFS_THRESHOLD, 32'hffff_fffa);
        rd(OFS_THRESHOLD, 32'ha);
        chk({28'h0, rsel}, 32'ha);
        wr(OFS_SPECIAL_EN, 32'hf);
        wr(8'hc0, 32'h80);
        settle();
        chk(word, fx(6'h2d, 4'hf));
        chk({31'h0, trip}, 32'h0);
        wr(OFS_INVERT, 32'h3);
        settle();
        chk(word, fx(6'h2e, 4'hf));
        wr(OFS_FORCE_EN, 32'h3);
        wr(OFS_FORCE_VAL, 32'h1);
        settle();
        chk(word, fx(6'h2d, 4'hf));
        lvl <= 6'h10;
        settle();
        chk(word, fx(6'h11, 4'hf));
        rd(OFS_RAW, 32'h10);
        wr(OFS_FORCE_EN, 32'h0);
        wr(OFS_INVERT, 32'h0);
        lvl <= 6'h2d;
        wr(OFS_ROUTE_EN, 32'h1);
        settle();
        chk(word, fx(6'h2d, 4'hf));
        rd(8'hc0, 32'h1);
        foreach (CD[i]) begin
            wr(8'hc0, {24'h0, CD[i]});
            settle();
            chk({31'h0, word[16]}, {31'h0, EX[i]});
        end
        wr(8'h8c, 32'h4);
        lvl <= 6'h25;
        settle();
        chk({31'h0, trip}, 32'h1);
        wr(8'h8c, 32'h84);
        settle();
        chk({31'h0, trip}, 32'h0);
        wr(OFS_ROUTE_EN, 32'h0);
        wr(8'h18, 32'hffff_ffff);
        wr(OFS_RAW, 32'h3f);
        settle();
        chk(word, fx(6'h25, 4'hf));
        chk({31'h0, trip}, 32'h1);
        wr(OFS_SPECIAL_EN, 32'h2);
        settle();
        chk(word, fx(6'h25, 4'h2));
        chk({31'h0, trip}, 32'h0);
        rd(8'h18, 32'h0);
        rd(OFS_RAW, 32'h25);
        give_verdict();
    end
endmodule : tb_top
